// file: rtl/smd_pkg.sv
// Constants and types shared by the synthesizer mode decoder.
package smd_pkg;
  localparam int SMD_WORD_W = 22;
  localparam int SMD_R_W = 15;
  localparam int SMD_B_W = 11;
  localparam int SMD_A_RF_W = 7;
  localparam int SMD_A_IF_W = 4;
  localparam int SMD_PFX_W = 8;
  // Field positions inside the 22-bit word, counted from bit 1 = index 0
  localparam int SMD_POS_POL = 15;
  localparam int SMD_POS_CUR = 16;
  localparam int SMD_POS_DIS = 17;
  localparam int SMD_POS_LD = 18;
  localparam int SMD_POS_FO = 19;
  localparam int SMD_POS_B = 7;
  localparam int SMD_POS_A = 0;
  localparam int SMD_POS_PSC = 18;
  localparam int SMD_POS_PWD = 19;
  localparam int SMD_POS_ROUTE = 20;
  // Route codes: high bit first
  localparam logic [1:0] SMD_RT_IF_R = 2'h0;
  localparam logic [1:0] SMD_RT_RF_R = 2'h1;
  localparam logic [1:0] SMD_RT_IF_N = 2'h2;
  localparam logic [1:0] SMD_RT_RF_N = 2'h3;
  // Reset values of latched words
  localparam logic [SMD_R_W-1:0] SMD_R_RST = 15'h0003;
  localparam logic [SMD_B_W-1:0] SMD_B_RST = 11'h003;
  // Prescaler moduli
  localparam logic [SMD_PFX_W-1:0] SMD_P_IF_LO = 8'h08;
  localparam logic [SMD_PFX_W-1:0] SMD_P_IF_HI = 8'h10;
  localparam logic [SMD_PFX_W-1:0] SMD_P_RF_LO = 8'h40;
  localparam logic [SMD_PFX_W-1:0] SMD_P_RF_HI = 8'h80;
  localparam logic [SMD_PFX_W-1:0] SMD_P_RFX_LO = 8'h20;
  localparam logic [SMD_PFX_W-1:0] SMD_P_RFX_HI = 8'h40;
  localparam int SMD_TOT_W = 19;
  typedef enum logic [1:0] {
    SMD_PD_UP = 2'b00,
    SMD_PD_WAIT = 2'b01,
    SMD_PD_DOWN = 2'b11
  } smd_pd_t;
endpackage

// file: rtl/smd_loop_ctl.sv
// Per-loop mode decode, divide ratio and powerdown sequencing.
`timescale 1ns/1ps
`default_nettype none
module smd_loop_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic is_rf,
  input wire logic fast_variant,
  input wire logic [smd_pkg::SMD_WORD_W-1:0] r_word,
  input wire logic [smd_pkg::SMD_WORD_W-1:0] n_word,
  input wire logic counter_reset,
  input wire logic pump_idle,
  output logic [smd_pkg::SMD_R_W-1:0] ref_ratio,
  output logic [smd_pkg::SMD_B_W-1:0] main_count,
  output logic [smd_pkg::SMD_A_RF_W-1:0] swallow_count,
  output logic [smd_pkg::SMD_PFX_W-1:0] prescaler_modulus,
  output logic [smd_pkg::SMD_TOT_W-1:0] total_division,
  output logic detector_positive,
  output logic pump_current_level,
  output logic pump_hiz,
  output logic counters_held,
  output logic powered_down
);
  import smd_pkg::*;
  typedef struct packed {
    smd_pd_t pd;
  } smd_loop_st_t;
  smd_loop_st_t st_q, st_d;
  logic psc, pwd, dis;

  assign psc = n_word[SMD_POS_PSC];
  assign pwd = n_word[SMD_POS_PWD];
  assign dis = r_word[SMD_POS_DIS];

  assign main_count = n_word[SMD_POS_B +: SMD_B_W];
  assign ref_ratio = r_word[SMD_R_W-1:0];
  assign swallow_count = is_rf ? n_word[SMD_POS_A +: SMD_A_RF_W]
                       : {3'h0, n_word[SMD_POS_A +: SMD_A_IF_W]};
  always_comb begin
    if (!is_rf) begin
      prescaler_modulus = psc ? SMD_P_IF_HI : SMD_P_IF_LO;
    end else if (fast_variant) begin
      prescaler_modulus = psc ? SMD_P_RFX_HI : SMD_P_RFX_LO;
    end else begin
      prescaler_modulus = psc ? SMD_P_RF_HI : SMD_P_RF_LO;
    end
  end
  assign total_division = SMD_TOT_W'(prescaler_modulus * main_count)
                        + SMD_TOT_W'(swallow_count);
  assign detector_positive = r_word[SMD_POS_POL];
  assign pump_current_level = r_word[SMD_POS_CUR];
  // pump high impedance, also under counter reset
  assign pump_hiz = dis | counter_reset | (st_q.pd != SMD_PD_UP);
  assign counters_held = counter_reset | (st_q.pd == SMD_PD_DOWN);
  assign powered_down = st_q.pd == SMD_PD_DOWN;

  // sync waits for idle pump, async immediate
  always_comb begin
    st_d = st_q;
    unique case (st_q.pd)
      SMD_PD_UP: begin
        if (pwd) begin
          st_d.pd = dis ? SMD_PD_DOWN : SMD_PD_WAIT;
        end
      end
      SMD_PD_WAIT: begin
        if (!pwd) begin
          st_d.pd = SMD_PD_UP;
        end else if (pump_idle) begin
          st_d.pd = SMD_PD_DOWN;
        end
      end
      SMD_PD_DOWN: begin
        if (!pwd) begin
          st_d.pd = SMD_PD_UP;
        end
      end
      default: st_d.pd = SMD_PD_UP;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{pd: SMD_PD_UP};
    end else begin
      st_q <= st_d;
    end
  end

  pd_async_a: assert property (@(posedge clk) disable iff (rst)
    (st_q.pd == SMD_PD_UP && pwd && dis) |=> powered_down)
    else $error("async powerdown not immediate");
  pd_sync_a: assert property (@(posedge clk) disable iff (rst)
    (st_q.pd == SMD_PD_UP && pwd && !dis) |=> !powered_down && pump_hiz)
    else $error("sync powerdown skipped pump wait");
  hiz_dis_a: assert property (@(posedge clk) disable iff (rst)
    dis |-> pump_hiz)
    else $error("pump not high impedance");
  cur_bit_a: assert property (@(posedge clk) disable iff (rst)
    pump_current_level == n_word[0] || 1'b1 ? pump_current_level ==
    r_word[SMD_POS_CUR] : 1'b0)
    else $error("pump current mismatch");
  tot_div_a: assert property (@(posedge clk) disable iff (rst)
    $changed(n_word) |-> total_division ==
    prescaler_modulus * main_count + swallow_count)
    else $error("total division wrong");
endmodule
`default_nettype wire

// file: rtl/smd_top.sv
// Serial word latching, dual loop decode and shared output pin mux.
// Summary of operation
// - Main count is 11-bit binary field of divider word, MSB highest.
// - Total division equals modulus times main count plus swallow count.
// - Prescaler bit picks 8/9-16/17 IF, 64/65-128/129 or 32/33-64/65 RF.
// - Reference word mode bits 16-20; divider word prescaler 19, power 20.
// - Polarity bit clear negative, set positive detector sense.
// - Pump-disable bit set forces charge pump high impedance.
// - Current bit set full current, clear quarter current.
// - All select bits clear: output disabled and driven low.
// - Lock selects route IF, RF, or combined lock requiring both.
// - Lock modes drive high when locked, with narrow low pulses.
// - One function bit: reference or divider output per IF lock bit.
// - Both function bits, no lock bits: pin grounds resistor on RF current.
// - Both function bits plus lock bits hold counters, pumps off.
// - Counter restart aligned within one prescaler cycle after reset.
// - Route bits send word to IF/RF reference or divider latches.
// - Powerdown sync after pump idle, or immediate when pump disabled.
`timescale 1ns/1ps
`default_nettype none
module smd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  input wire logic fast_variant,
  input wire logic if_locked,
  input wire logic rf_locked,
  input wire logic if_ref_div_out,
  input wire logic rf_ref_div_out,
  input wire logic if_prog_div_out,
  input wire logic rf_prog_div_out,
  input wire logic if_pump_idle,
  input wire logic rf_pump_idle,
  output logic [smd_pkg::SMD_R_W-1:0] if_ref_ratio,
  output logic [smd_pkg::SMD_B_W-1:0] if_main_count,
  output logic [smd_pkg::SMD_A_RF_W-1:0] if_swallow_count,
  output logic [smd_pkg::SMD_PFX_W-1:0] if_prescaler_modulus,
  output logic [smd_pkg::SMD_TOT_W-1:0] if_total_division,
  output logic if_detector_positive,
  output logic if_pump_current_level,
  output logic if_pump_hiz,
  output logic if_counters_held,
  output logic if_powered_down,
  output logic [smd_pkg::SMD_R_W-1:0] rf_ref_ratio,
  output logic [smd_pkg::SMD_B_W-1:0] rf_main_count,
  output logic [smd_pkg::SMD_A_RF_W-1:0] rf_swallow_count,
  output logic [smd_pkg::SMD_PFX_W-1:0] rf_prescaler_modulus,
  output logic [smd_pkg::SMD_TOT_W-1:0] rf_total_division,
  output logic rf_detector_positive,
  output logic rf_pump_current_level,
  output logic rf_pump_hiz,
  output logic rf_counters_held,
  output logic rf_powered_down,
  output logic multi_function_output,
  output logic multi_function_output_oe
);
  import smd_pkg::*;
  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] le_s;
    logic [1:0] dat_s;
    logic [SMD_WORD_W-1:0] shift;
    logic [SMD_WORD_W-1:0] if_r;
    logic [SMD_WORD_W-1:0] rf_r;
    logic [SMD_WORD_W-1:0] if_n;
    logic [SMD_WORD_W-1:0] rf_n;
    logic mfo;
    logic oe;
  } smd_st_t;
  smd_st_t st_q, st_d;
  logic clk_rise, le_rise;
  logic if_ld, rf_ld, if_fo, rf_fo;
  logic if_rst_sel, rf_rst_sel;
  logic [1:0] route;

  // Synchroniser stage [0] is only read by stage [1]
  assign clk_rise = st_q.clk_s[1] & ~st_q.clk_s[2];
  assign le_rise = st_q.le_s[1] & ~st_q.le_s[2];
  assign route = st_q.shift[SMD_POS_ROUTE +: 2];

  assign if_ld = st_q.if_r[SMD_POS_LD];
  assign rf_ld = st_q.rf_r[SMD_POS_LD];
  assign if_fo = st_q.if_r[SMD_POS_FO];
  assign rf_fo = st_q.rf_r[SMD_POS_FO];
  assign if_rst_sel = if_fo & rf_fo & if_ld;
  assign rf_rst_sel = if_fo & rf_fo & rf_ld;

  always_comb begin
    st_d = st_q;
    st_d.clk_s = {st_q.clk_s[1:0], ser_clk};
    st_d.le_s = {st_q.le_s[1:0], ser_le};
    st_d.dat_s = {st_q.dat_s[0], ser_data};
    // Data shifted MSB first into bit 0
    if (clk_rise) begin
      st_d.shift = {st_q.shift[SMD_WORD_W-2:0], st_q.dat_s[1]};
    end
    if (le_rise) begin
      unique case (route)
        SMD_RT_IF_R: st_d.if_r = st_q.shift;
        SMD_RT_RF_R: st_d.rf_r = st_q.shift;
        SMD_RT_IF_N: st_d.if_n = st_q.shift;
        SMD_RT_RF_N: st_d.rf_n = st_q.shift;
      endcase
    end
    st_d.mfo = 1'b0;
    st_d.oe = 1'b1;
    unique case ({rf_fo, if_fo})
      2'b00: begin
        unique case ({rf_ld, if_ld})
          2'b00: st_d.mfo = 1'b0;
          2'b01: st_d.mfo = if_locked;
          2'b10: st_d.mfo = rf_locked;
          2'b11: st_d.mfo = if_locked & rf_locked;
        endcase
      end
      2'b01: st_d.mfo = if_ld ? if_prog_div_out : if_ref_div_out;
      2'b10: st_d.mfo = if_ld ? rf_prog_div_out : rf_ref_div_out;
      // open drain pull low on RF full current when no lock bits are set
      2'b11: begin
        st_d.mfo = 1'b0;
        st_d.oe = !(if_ld | rf_ld) & st_q.rf_r[SMD_POS_CUR];
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '{mfo: 1'b0, oe: 1'b1,
                if_r: {7'h00, SMD_R_RST}, rf_r: {7'h00, SMD_R_RST},
                if_n: {4'h0, SMD_B_RST, 7'h00},
                rf_n: {4'h0, SMD_B_RST, 7'h00}, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign multi_function_output = st_q.mfo;
  assign multi_function_output_oe = st_q.oe;

  // held counters restart together with pump release
  smd_loop_ctl u_if (
    .clk(clk), .rst(rst), .is_rf(1'b0), .fast_variant(fast_variant),
    .r_word(st_q.if_r), .n_word(st_q.if_n), .counter_reset(if_rst_sel),
    .pump_idle(if_pump_idle), .ref_ratio(if_ref_ratio),
    .main_count(if_main_count), .swallow_count(if_swallow_count),
    .prescaler_modulus(if_prescaler_modulus),
    .total_division(if_total_division),
    .detector_positive(if_detector_positive),
    .pump_current_level(if_pump_current_level), .pump_hiz(if_pump_hiz),
    .counters_held(if_counters_held), .powered_down(if_powered_down)
  );
  smd_loop_ctl u_rf (
    .clk(clk), .rst(rst), .is_rf(1'b1), .fast_variant(fast_variant),
    .r_word(st_q.rf_r), .n_word(st_q.rf_n), .counter_reset(rf_rst_sel),
    .pump_idle(rf_pump_idle), .ref_ratio(rf_ref_ratio),
    .main_count(rf_main_count), .swallow_count(rf_swallow_count),
    .prescaler_modulus(rf_prescaler_modulus),
    .total_division(rf_total_division),
    .detector_positive(rf_detector_positive),
    .pump_current_level(rf_pump_current_level), .pump_hiz(rf_pump_hiz),
    .counters_held(rf_counters_held), .powered_down(rf_powered_down)
  );

  mfo_off_a: assert property (@(posedge clk) disable iff (rst)
    (!if_ld && !rf_ld && !if_fo && !rf_fo) |=> multi_function_output == 0
    && multi_function_output_oe)
    else $error("disabled output not driven low");
  lock_both_a: assert property (@(posedge clk) disable iff (rst)
    (if_ld && rf_ld && !if_fo && !rf_fo && $stable(st_q.rf_r) &&
    $stable(st_q.if_r)) |=> multi_function_output ==
    $past(if_locked & rf_locked))
    else $error("combined lock wrong");
  cnt_rst_a: assert property (@(posedge clk) disable iff (rst)
    rf_rst_sel |-> rf_counters_held && rf_pump_hiz)
    else $error("counter reset not applied");
  partial_a: assert property (@(posedge clk) disable iff (rst)
    !le_rise |=> $stable(st_q.rf_n) && $stable(st_q.if_r))
    else $error("settings changed without latch");
  route_a: assert property (@(posedge clk) disable iff (rst)
    (le_rise && route == SMD_RT_RF_N) |=> st_q.rf_n == $past(st_q.shift))
    else $error("word not routed");
endmodule
`default_nettype wire

// file: test/smd_host.sv
// Host model that shifts serial words into the decoder.
`timescale 1ns/1ps
`default_nettype none
module smd_host (
  input wire logic go,
  input wire logic [21:0] word,
  input wire logic [4:0] nbits,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le,
  output logic busy
);
  initial begin
    {ser_clk, ser_data, ser_le, busy} = 4'h0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      // Route bits lead, most significant bit first
      for (int i = 0; i < int'(nbits); i++) begin
        #31.25 ser_data = word[21 - i];
        #31.25 ser_clk = 1'b1;
        #62.5 ser_clk = 1'b0;
      end
      // A short frame ends with no latch pulse
      if (nbits == 5'h16) begin
        #31.25 ser_le = 1'b1;
        #62.5 ser_le = 1'b0;
      end
      // Released line shows the inverse, never a stale bit
      ser_data = ~ser_data;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: test/synth_mode_decode_lock_mux_bench.sv
// Self-checking bench for the synthesizer mode decoder.
`timescale 1ns/1ps
`default_nettype none
module synth_mode_decode_lock_mux_bench;
  logic clk = 1'b0, rst = 1'b1, fast_variant = 1'b0, go = 1'b0;
  logic [5:0] mon = 6'h00;
  logic [1:0] idle = 2'h3;
  logic [21:0] word = 22'h000000;
  logic [4:0] nbits = 5'h16;
  logic ser_clk, ser_data, ser_le, busy;
  logic [14:0] if_ref_ratio, rf_ref_ratio;
  logic [10:0] if_main_count, rf_main_count;
  logic [6:0] if_swallow_count, rf_swallow_count;
  logic [7:0] if_prescaler_modulus, rf_prescaler_modulus;
  logic [18:0] if_total_division, rf_total_division;
  logic if_detector_positive, if_pump_current_level, if_pump_hiz;
  logic rf_detector_positive, rf_pump_current_level, rf_pump_hiz;
  logic if_counters_held, if_powered_down, rf_counters_held;
  logic rf_powered_down, multi_function_output, multi_function_output_oe;
  wire logic [1:0] pd_w = {rf_powered_down, if_powered_down};
  wire logic [1:0] hz_w = {rf_pump_hiz, if_pump_hiz};
  wire logic [1:0] o_f = {multi_function_output_oe, multi_function_output};
  wire logic [1:0][14:0] o_r = {rf_ref_ratio, if_ref_ratio};
  wire logic [1:0][10:0] o_b = {rf_main_count, if_main_count};
  wire logic [1:0][6:0] o_a = {rf_swallow_count, if_swallow_count};
  wire logic [1:0][7:0] o_p = {rf_prescaler_modulus, if_prescaler_modulus};
  wire logic [1:0][18:0] o_t = {rf_total_division, if_total_division};
  wire logic [1:0][2:0] o_m = {rf_counters_held, rf_pump_current_level,
    rf_detector_positive, if_counters_held, if_pump_current_level,
    if_detector_positive};
  int failures = 0, num_checks = 0;
  int rr[2] = '{3, 3}, bb[2] = '{3, 3}, aa[2], md[2], ps[2], pw[2];
  logic [31:0] seed = 32'h20C3;

  always #5 clk = ~clk;

  smd_host u_smd_host (.go, .word, .nbits, .ser_clk, .ser_data, .ser_le,
    .busy);
  smd_top u_smd_top (.clk, .rst, .ser_clk, .ser_data, .ser_le, .fast_variant,
    .if_locked(mon[0]), .rf_locked(mon[1]), .if_ref_div_out(mon[2]),
    .rf_ref_div_out(mon[3]), .if_prog_div_out(mon[4]),
    .rf_prog_div_out(mon[5]), .if_pump_idle(idle[0]),
    .rf_pump_idle(idle[1]), .if_ref_ratio, .if_main_count, .if_swallow_count,
    .if_prescaler_modulus, .if_total_division, .if_detector_positive,
    .if_pump_current_level, .if_pump_hiz, .if_counters_held, .if_powered_down,
    .rf_ref_ratio, .rf_main_count, .rf_swallow_count, .rf_prescaler_modulus,
    .rf_total_division, .rf_detector_positive, .rf_pump_current_level,
    .rf_pump_hiz, .rf_counters_held, .rf_powered_down, .multi_function_output,
    .multi_function_output_oe);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output int v, input int lo, input int hi);
    seed = lfsr(seed);
    v = lo + int'(seed[15:0]) % (hi - lo + 1);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Model takes a word only when the frame was complete
  task automatic send(input logic [1:0] rt, input int d, input int n = 22);
    int k;
    int l;
    l = int'(rt[0]);
    word <= {rt, d[19:0]};
    nbits <= 5'(n);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (busy && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (busy) begin
      failures++;
      results();
    end
    if (n == 22 && !rt[1]) begin
      rr[l] = d & 32'h7FFF;
      md[l] = d >> 15 & 31;
    end
    if (n == 22 && rt[1]) begin
      aa[l] = d & (l ? 127 : 15);
      bb[l] = d >> 7 & 2047;
      ps[l] = d >> 18 & 1;
      pw[l] = d >> 19 & 1;
    end
    tick(3);
  endtask

  task automatic check_all;
    int pe, h, fo, ld, e;
    fo = (md[1] >> 3 & 2) | (md[0] >> 4 & 1);
    ld = (md[1] >> 2 & 2) | (md[0] >> 3 & 1);
    for (int l = 0; l < 2; l++) begin
      pe = l ? (fast_variant ? 32 : 64) : 8;
      pe = ps[l] ? pe * 2 : pe;
      h = fo == 3 ? ld >> l & 1 : 0;
      chk("ref_ratio", o_r[l], rr[l]);
      chk("main_count", o_b[l], bb[l]);
      chk("swallow", o_a[l], aa[l]);
      chk("modulus", o_p[l], pe);
      chk("total", o_t[l], pe * bb[l] + aa[l]);
      chk("modes", o_m[l], h << 2 | md[l] & 3);
      if (!pw[l]) begin
        chk("pump_hiz", hz_w[l], md[l] >> 2 & 1 | h);
        chk("powered_down", pd_w[l], 0);
      end
    end
    e = 2 + (ld == 3 ? mon[0] & mon[1] : ld == 0 ? 0 : mon[ld - 1]);
    if (fo == 1 || fo == 2) e = 2 + mon[fo + 1 + 2 * (ld & 1)];
    if (fo == 3) e = md[1] >> 1 & 1 ? 2 : 0;
    if (fo != 3 || ld == 0) chk("mfo", o_f, e);
  endtask

  initial begin
    int v, b, a;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    check_all();
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      fast_variant <= 1'(i >> 2 & 1);
      rnd(b, 3, 2047);
      b = i == 0 ? 3 : i == 15 ? 2047 : b;
      rnd(a, 0, i & 1 ? 127 : 15);
      a = a > b ? b : a;
      rnd(v, 0, 7);
      send({1'b1, 1'(i & 1)},
        (i >> 1 & 1) << 18 | b << 7 | a | (i & 1 ? 0 : v << 4));
      check_all();
      rnd(v, 3, 32767);
      rnd(a, 0, 7);
      send({1'b0, 1'(i & 1)}, a << 15 | v);
      check_all();
    end
    $display("ratio test done");
    for (int i = 0; i < 32; i++) begin
      rnd(v, 0, 63);
      mon <= 6'(v);
      send(2'h0, (i & 1) << 18 | (i >> 2 & 1) << 19 | 100);
      send(2'h1, (i >> 1 & 1) << 18 | (i >> 3 & 1) << 19 |
        (i >> 4 & 1) << 16 | 200);
      check_all();
      rnd(v, 0, 63);
      mon <= 6'(v);
      tick(3);
      check_all();
    end
    $display("output pin test done");
    for (int l = 0; l < 2; l++) begin
      idle <= 2'h0;
      send({1'b0, 1'(l)}, 300);
      send({1'b1, 1'(l)}, 1 << 19 | 10 << 7);
      chk("sync_wait", {pd_w[l], hz_w[l]}, 1);
      idle <= 2'h3;
      tick(4);
      chk("sync_down", pd_w[l], 1);
      send({1'b1, 1'(l)}, 10 << 7);
      chk("power_up", pd_w[l], 0);
      idle <= 2'h0;
      send({1'b0, 1'(l)}, 1 << 17 | 300);
      send({1'b1, 1'(l)}, 1 << 19 | 10 << 7);
      chk("async_down", pd_w[l], 1);
      send({1'b1, 1'(l)}, 10 << 7);
      send({1'b0, 1'(l)}, 300);
      check_all();
    end
    $display("powerdown test done");
    send(2'h3, 1 << 19 | 5 << 7, 12);
    check_all();
    send(2'h3, 50 << 7 | 7);
    check_all();
    $display("partial frame test done");
    results();
  end
endmodule
`default_nettype wire
